// *** mam_pkg.sv ***
// Constants, field positions and carrier types of the memory address map
package mam_pkg;

    // Widths of the program and data paths
    localparam int PC_W      = 13;
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int OFS_W     = 7;
    localparam int DADDR_W   = 9;
    localparam int PROG_AW   = 11;
    localparam int PROG_DEPTH = 2048;
    localparam int DATA_DEPTH = 512;

    // Program counter vectors and step
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR   = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP      = 13'h0001;

    // Implemented program words: 1K small variant, 2K large variant
    localparam logic [PROG_AW-1:0] PROG_MASK_SMALL = 11'h3ff;
    localparam logic [PROG_AW-1:0] PROG_MASK_LARGE = 11'h7ff;

    // Status bit positions
    localparam int STAT_IND_HI   = 7;
    localparam int STAT_BANK_HI  = 6;
    localparam int STAT_BANK_LO  = 5;

    // Bank layout
    localparam logic [OFS_W-1:0] BANK_TOP     = 7'h7f;
    localparam logic [OFS_W-1:0] GPR_BASE     = 7'h20;
    localparam logic [OFS_W-1:0] OFS_INDIRECT = 7'h00;
    localparam logic [OFS_W-1:0] OFS_PC_LOW   = 7'h02;
    localparam logic [OFS_W-1:0] OFS_STATUS   = 7'h03;
    localparam logic [OFS_W-1:0] OFS_POINTER  = 7'h04;

    // Data EEPROM address pointer, bank 2 only
    localparam logic [DADDR_W-1:0] ADDR_EE_POINTER = 9'h10d;
    localparam logic [DATA_W-1:0]  EE_MASK_SMALL   = 8'h7f;
    localparam logic [DATA_W-1:0]  EE_MASK_LARGE   = 8'hff;

    // Values after reset
    localparam logic [DATA_W-1:0] STATUS_RST  = 8'h00;
    localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
    localparam logic [DATA_W-1:0] EE_PTR_RST  = 8'h00;

    // Decoded class of a data address
    typedef enum logic [1:0] {
        CLS_INDIRECT = 2'b00,
        CLS_SPECIAL  = 2'b01,
        CLS_GPR      = 2'b10
    } mam_class_t;

    // One data bus request
    typedef struct packed {
        logic                valid;
        logic                write;
        logic [OFS_W-1:0]    offset;
        logic [DATA_W-1:0]   wdata;
    } mam_dreq_t;

    // Program memory load request
    typedef struct packed {
        logic                write;
        logic [PROG_AW-1:0]  addr;
        logic [INSTR_W-1:0]  wdata;
    } mam_pload_t;

    // All state of the map
    typedef struct packed {
        logic [PC_W-1:0]     pc;
        logic [DATA_W-1:0]   status;
        logic [DATA_W-1:0]   pointer;
        logic [DATA_W-1:0]   ee_ptr;
        logic [DATA_W-1:0]   spec_q;
        logic                from_ram;
        logic                rd_valid;
        logic                instr_valid;
    } mam_state_t;

endpackage : mam_pkg

// *** mam_mem.sv ***
// Single-port-write, registered-read memory array
`timescale 1ns/1ns
`default_nettype none

module mam_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_ff
);

    logic [WIDTH-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // Array write, no reset on storage
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (re) begin
            rdata_ff <= mem[raddr];
        end
    end

endmodule : mam_mem

`default_nettype wire

// *** mam_map.sv ***
// Program and data memory address map of the core
//
// Operation
// (R1) Program fetch and data access use separate buses, both served each cycle.
// (R2) Program counter is thirteen bits, addressing 8K fourteen-bit words.
// (R3) Small variant implements program words 0000h to 03FFh only.
// (R4) Large variant implements program words 0000h to 07FFh.
// (R5) Fetches above the implemented range wrap by dropping upper counter bits.
// (R6) Any reset loads the program counter with zero.
// (R7) A taken interrupt loads the program counter with 0004h.
// (R8) Status bits six and five select data bank zero to three.
// (R9) Each bank spans offsets 00h to 7Fh, 128 bytes.
// (R10) Low offsets decode to special registers, higher offsets to static RAM.
// (R11) Busy special registers mirror across banks; status is in all four.
// (R12) Data EEPROM is not mapped; an address pointer register selects its byte.
// (R13) EEPROM pointer spans 00h-7Fh small variant, 00h-FFh large variant.
// (R14) Register file reachable directly and indirectly via the pointer register.
// (R15) Direct data address is bank bits above the seven-bit offset.
`timescale 1ns/1ns
`default_nettype none

module mam_map
    import mam_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Fetch control
    input  wire logic                 fetch_en,
    input  wire logic                 int_take,
    input  wire logic                 pc_load,
    input  wire logic [PC_W-1:0]      pc_target,
    // Program memory load
    input  wire mam_pload_t           pload,
    // Data bus request
    input  wire mam_dreq_t            dreq,
    // Fetch results
    output logic      [PC_W-1:0]      pc,
    output logic      [INSTR_W-1:0]   instr,
    output logic                      instr_valid,
    // Data read results
    output logic      [DATA_W-1:0]    rd_data,
    output logic                      rd_valid,
    // Map state
    output logic      [1:0]           bank,
    output logic      [DATA_W-1:0]    ee_addr,
    output logic      [DATA_W-1:0]    status_q
);

    localparam logic [PROG_AW-1:0] PROG_MASK = LARGE ? PROG_MASK_LARGE : PROG_MASK_SMALL;
    localparam logic [DATA_W-1:0]  EE_MASK   = LARGE ? EE_MASK_LARGE : EE_MASK_SMALL;

    mam_state_t            st_ff;
    mam_state_t            nxt_st;
    logic [INSTR_W-1:0]    prog_q;
    logic [DATA_W-1:0]     ram_q;
    logic [DADDR_W-1:0]    eff_addr;
    mam_class_t            eff_cls;
    logic                  ram_we;
    logic                  ram_re;
    logic [PROG_AW-1:0]    fetch_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Class of a full data address from its in-bank offset
    function automatic mam_class_t classify(input logic [DADDR_W-1:0] addr);
        logic [OFS_W-1:0] ofs;
        ofs = addr[OFS_W-1:0];
        if (ofs == OFS_INDIRECT) begin
            classify = CLS_INDIRECT;
        end else if (ofs < GPR_BASE) begin
            classify = CLS_SPECIAL; // R10
        end else begin
            classify = CLS_GPR; // R10
        end
    endfunction : classify

    // Read value of a special register, mirrored ones by offset alone
    function automatic logic [DATA_W-1:0] special_value(input logic [DADDR_W-1:0] addr,
                                                       input mam_state_t s);
        logic [OFS_W-1:0] ofs;
        ofs = addr[OFS_W-1:0];
        if (ofs == OFS_STATUS) begin
            special_value = s.status; // R11
        end else if (ofs == OFS_POINTER) begin
            special_value = s.pointer; // R11
        end else if (ofs == OFS_PC_LOW) begin
            special_value = s.pc[DATA_W-1:0]; // R11
        end else if (addr == ADDR_EE_POINTER) begin
            special_value = s.ee_ptr; // R12
        end else begin
            special_value = '0;
        end
    endfunction : special_value

    ////////////////////////////////////////////////////////////////////////////////
    // Effective data address
    always_comb begin
        if (dreq.offset == OFS_INDIRECT) begin
            eff_addr = {st_ff.status[STAT_IND_HI], st_ff.pointer}; // R14
        end else begin
            eff_addr = {st_ff.status[STAT_BANK_HI], st_ff.status[STAT_BANK_LO],
                        dreq.offset}; // R8 R9 R15
        end
        eff_cls = classify(eff_addr);
    end

    // Static RAM strobes, independent of the fetch path
    assign ram_we = dreq.valid && dreq.write && (eff_cls == CLS_GPR); // R1 R10
    assign ram_re = dreq.valid && !dreq.write && (eff_cls == CLS_GPR); // R1 R10

    // Fetch address keeps only the implemented low bits
    assign fetch_addr = st_ff.pc[PROG_AW-1:0] & PROG_MASK; // R3 R4 R5

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd_valid = 1'b0;
        nxt_st.instr_valid = fetch_en;

        // Program counter: interrupt over jump over advance
        if (int_take) begin
            nxt_st.pc = INT_VECTOR; // R7
        end else if (pc_load) begin
            nxt_st.pc = pc_target; // R2
        end else if (fetch_en) begin
            nxt_st.pc = PC_W'(st_ff.pc + PC_STEP); // R2
        end

        // Data access on its own bus
        if (dreq.valid) begin
            case (eff_cls)
                CLS_SPECIAL: begin
                    if (dreq.write) begin
                        if (eff_addr[OFS_W-1:0] == OFS_STATUS) begin
                            nxt_st.status = dreq.wdata; // R8 R11
                        end else if (eff_addr[OFS_W-1:0] == OFS_POINTER) begin
                            nxt_st.pointer = dreq.wdata; // R14
                        end else if (eff_addr == ADDR_EE_POINTER) begin
                            nxt_st.ee_ptr = dreq.wdata & EE_MASK; // R12 R13
                        end
                    end else begin
                        nxt_st.spec_q = special_value(eff_addr, st_ff);
                        nxt_st.from_ram = 1'b0;
                        nxt_st.rd_valid = 1'b1;
                    end
                end
                CLS_GPR: begin
                    if (!dreq.write) begin
                        nxt_st.from_ram = 1'b1;
                        nxt_st.rd_valid = 1'b1;
                    end
                end
                CLS_INDIRECT: begin
                    // Indirect through the indirect slot itself reads zero
                    if (!dreq.write) begin
                        nxt_st.spec_q = '0;
                        nxt_st.from_ram = 1'b0;
                        nxt_st.rd_valid = 1'b1;
                    end
                end
                default: begin
                    nxt_st.rd_valid = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{pc: RESET_VECTOR, status: STATUS_RST, pointer: POINTER_RST,
                       ee_ptr: EE_PTR_RST, spec_q: '0, from_ram: 1'b0,
                       rd_valid: 1'b0, instr_valid: 1'b0}; // R6
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program flash array
    mam_mem #(
        .WIDTH (INSTR_W),
        .DEPTH (PROG_DEPTH),
        .AW    (PROG_AW)
    ) u_prog (
        .clk      (clk),
        .rst      (rst),
        .we       (pload.write),
        .waddr    (pload.addr & PROG_MASK), // R5
        .wdata    (pload.wdata),
        .re       (fetch_en), // R1
        .raddr    (fetch_addr),
        .rdata_ff (prog_q)
    );

    // General-purpose static RAM, indexed by full bank address
    mam_mem #(
        .WIDTH (DATA_W),
        .DEPTH (DATA_DEPTH),
        .AW    (DADDR_W)
    ) u_ram (
        .clk      (clk),
        .rst      (rst),
        .we       (ram_we),
        .waddr    (eff_addr),
        .wdata    (dreq.wdata),
        .re       (ram_re),
        .raddr    (eff_addr),
        .rdata_ff (ram_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pc          = st_ff.pc;
    assign instr       = prog_q;
    assign instr_valid = st_ff.instr_valid;
    assign rd_data     = st_ff.from_ram ? ram_q : st_ff.spec_q;
    assign rd_valid    = st_ff.rd_valid;
    assign bank        = {st_ff.status[STAT_BANK_HI], st_ff.status[STAT_BANK_LO]}; // R8
    assign ee_addr     = st_ff.ee_ptr; // R12
    assign status_q    = st_ff.status;

endmodule : mam_map

`default_nettype wire

// *** mam_map_sva.sv ***
// Assertion checker for the memory address map
`timescale 1ns/1ns
`default_nettype none

module mam_map_sva
    import mam_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    // Clock, reset and fetch control
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               fetch_en,
    input wire logic               int_take,
    input wire logic               pc_load,
    input wire logic [PC_W-1:0]    pc_target,
    // Requests
    input wire mam_pload_t         pload,
    input wire mam_dreq_t          dreq,
    // Results and state
    input wire logic [PC_W-1:0]    pc,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic               instr_valid,
    input wire logic [DATA_W-1:0]  rd_data,
    input wire logic               rd_valid,
    input wire logic [1:0]         bank,
    input wire logic [DATA_W-1:0]  ee_addr,
    input wire logic [DATA_W-1:0]  status_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Fetch side
    fetch_ans_a: assert property (fetch_en |=> instr_valid)
        else $error("fetch without answer");
    fetch_idle_a: assert property (!fetch_en |=> !instr_valid)
        else $error("answer without fetch");
    int_vec_a: assert property (int_take |=> pc == INT_VECTOR)
        else $error("interrupt entry wrong");
    jump_tgt_a: assert property (!int_take && pc_load |=> pc == $past(pc_target))
        else $error("jump target wrong");
    pc_step_a: assert property (!int_take && !pc_load && fetch_en |=> pc == $past(pc) + PC_STEP)
        else $error("counter step wrong");
    pc_hold_a: assert property (!int_take && !pc_load && !fetch_en |=> $stable(pc))
        else $error("counter moved while idle");

    ////////////////////////////////////////////////////////////////////////////////
    // Data side
    bank_bits_a: assert property (bank == status_q[STAT_BANK_HI:STAT_BANK_LO])
        else $error("bank not from status bits");
    read_ans_a: assert property (dreq.valid && !dreq.write |=> rd_valid)
        else $error("read without answer");
    status_wr_a: assert property (dreq.valid && dreq.write && dreq.offset == OFS_STATUS
        |=> status_q == $past(dreq.wdata))
        else $error("status write lost");
    ee_range_a: assert property ((ee_addr & ~(LARGE ? EE_MASK_LARGE : EE_MASK_SMALL)) == 8'h00)
        else $error("eeprom pointer out of range");

    // Main scenarios reached
    cov_int: cover property (int_take ##1 instr_valid);
    cov_wrap: cover property (fetch_en && pc == 13'h1fff ##1 pc == 13'h0000);
    cov_ind: cover property (dreq.valid && !dreq.write && dreq.offset == OFS_INDIRECT);
endmodule : mam_map_sva

bind mam_map mam_map_sva #(.LARGE(LARGE)) u_sva (
    .clk(clk), .rst(rst), .fetch_en(fetch_en), .int_take(int_take), .pc_load(pc_load),
    .pc_target(pc_target), .pload(pload), .dreq(dreq), .pc(pc), .instr(instr),
    .instr_valid(instr_valid), .rd_data(rd_data), .rd_valid(rd_valid), .bank(bank),
    .ee_addr(ee_addr), .status_q(status_q));

`default_nettype wire

// *** tb_mam_map.sv ***
// Self-checking testbench for the memory address map
`timescale 1ns/1ns
`default_nettype none

module tb_mam_map
    import mam_pkg::*;
;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               fetch_en = 1'b0;
    logic               int_take = 1'b0;
    logic               pc_load = 1'b0;
    logic [PC_W-1:0]    pc_target = '0;
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    pcm;
    mam_pload_t         pload = '0;
    mam_dreq_t          dreq = '0;
    logic [INSTR_W-1:0] instr;
    logic               instr_valid;
    logic               rd_valid;
    logic [DATA_W-1:0]  rd_data;
    logic [DATA_W-1:0]  ee_addr;
    logic [DATA_W-1:0]  status_q;
    logic [DATA_W-1:0]  stat_m;
    logic [DATA_W-1:0]  d;
    logic [1:0]         bank;
    logic [INSTR_W-1:0] prog [PROG_DEPTH];
    logic [INSTR_W-1:0] prog_s [PROG_DEPTH/2];
    logic [DATA_W-1:0]  ram [DATA_DEPTH];
    logic [INSTR_W-1:0] q_i [$];
    logic [INSTR_W-1:0] q_s [$];
    logic [INSTR_W-1:0] instr_s;
    logic               instr_valid_s;
    logic [DATA_W-1:0]  ee_addr_s;
    logic [DATA_W-1:0]  q_d [$];
    int                 fails = 0;
    int                 n_tests = 0;
    int                 seed = 32;

    always #2 clk = ~clk;

    mam_map dut (
        .clk(clk), .rst(rst), .fetch_en(fetch_en), .int_take(int_take), .pc_load(pc_load),
        .pc_target(pc_target), .pload(pload), .dreq(dreq), .pc(pc), .instr(instr),
        .instr_valid(instr_valid), .rd_data(rd_data), .rd_valid(rd_valid), .bank(bank),
        .ee_addr(ee_addr), .status_q(status_q));

    // Small variant on the same stimulus
    mam_map #(.LARGE(1'b0)) dut_small (
        .clk(clk), .rst(rst), .fetch_en(fetch_en), .int_take(int_take), .pc_load(pc_load),
        .pc_target(pc_target), .pload(pload), .dreq(dreq), .pc(), .instr(instr_s),
        .instr_valid(instr_valid_s), .rd_data(), .rd_valid(), .bank(),
        .ee_addr(ee_addr_s), .status_q());

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, report and drive tasks
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic idle;
        @(posedge clk);
        fetch_en <= 1'b0;
        int_take <= 1'b0;
        pc_load <= 1'b0;
        dreq.valid <= 1'b0;
        pload.write <= 1'b0;
    endtask : idle

    // Fetch control for one cycle; notes the expected word and next counter
    task automatic step(logic fe, logic it, logic pl, logic [PC_W-1:0] tgt);
        @(posedge clk);
        fetch_en <= fe;
        int_take <= it;
        pc_load <= pl;
        pc_target <= tgt;
        if (fe) begin
            q_i.push_back(prog[pcm[PROG_AW-1:0]]);
            q_s.push_back(prog_s[pcm[PROG_AW-2:0]]);
        end
        pcm = it ? INT_VECTOR : pl ? tgt : fe ? pcm + PC_STEP : pcm;
    endtask : step

    // One data access; a read notes its expected byte
    task automatic dop(logic wr, logic [OFS_W-1:0] ofs, logic [DATA_W-1:0] dw,
                       logic [DATA_W-1:0] exp);
        @(posedge clk);
        dreq <= '{1'b1, wr, ofs, dw};
        if (!wr) begin
            q_d.push_back(exp);
        end
    endtask : dop

    // Result watcher, sampled where outputs are settled
    always @(negedge clk) begin
        if (!rst && instr_valid === 1'b1) begin
            chk("instr", q_i.size() > 0 ? q_i.pop_front() : 'x, instr);
        end
        if (!rst && rd_valid === 1'b1) begin
            chk("rd_data", q_d.size() > 0 ? q_d.pop_front() : 'x, rd_data);
        end
        if (!rst && instr_valid_s === 1'b1) begin
            chk("instr_small", q_s.size() > 0 ? q_s.pop_front() : 'x, instr_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("pc", RESET_VECTOR, pc);
        chk("ee_addr", EE_PTR_RST, ee_addr);
        pcm = RESET_VECTOR;
        // Load words at 000h-01Fh, 3F0h-40Fh and 7E0h-7FFh
        for (int i = 0; i < 96; i++) begin
            @(posedge clk);
            pload <= '{1'b1, 11'(i % 32 + (i / 32) * 'h3f0), 14'($random(seed))};
            @(negedge clk);
            prog[pload.addr] = pload.wdata;
            prog_s[pload.addr[PROG_AW-2:0]] = pload.wdata;
        end
        idle;
        // Back-to-back fetches, aliased jumps and counter wrap
        for (int i = 0; i < 3; i++) step(1'b1, 1'b0, 1'b0, '0);
        step(1'b1, 1'b0, 1'b1, 13'h0810);
        step(1'b1, 1'b0, 1'b1, 13'h1c00);
        step(1'b1, 1'b0, 1'b1, 13'h1ffe);
        for (int i = 0; i < 4; i++) step(1'b1, 1'b0, 1'b0, '0);
        step(1'b1, 1'b1, 1'b1, 13'h0800);
        step(1'b1, 1'b0, 1'b0, '0);
        idle;
        @(negedge clk);
        chk("pc", pcm, pc);
        // Same offset in every bank, status mirrored in each
        for (int b = 0; b < 4; b++) begin
            stat_m = {1'b0, b[1:0], 5'h00};
            d = 8'($random(seed));
            ram[{b[1:0], 7'h30}] = d;
            dop(1'b1, OFS_STATUS, stat_m, '0);
            dop(1'b1, 7'h30, d, '0);
            dop(1'b0, OFS_STATUS, '0, stat_m);
            dop(1'b0, 7'h30, '0, d);
            @(negedge clk);
            chk("bank", 16'(b[1:0]), bank);
            chk("status_q", stat_m, status_q);
        end
        // Indirect reads and the eeprom pointer, placed in bank 2 only
        dop(1'b1, OFS_STATUS, 8'h40, '0);
        dop(1'b1, 7'h0d, 8'ha5, '0);
        dop(1'b1, OFS_POINTER, 8'h30, '0);
        dop(1'b0, OFS_INDIRECT, '0, ram[9'h030]);
        dop(1'b1, OFS_STATUS, 8'h80, '0);
        dop(1'b1, 7'h0d, 8'h5a, '0);
        dop(1'b1, OFS_POINTER, 8'hb0, '0);
        dop(1'b0, OFS_INDIRECT, '0, ram[9'h1b0]);
        dop(1'b0, 7'h0d, '0, 8'h00);
        idle;
        @(negedge clk);
        chk("ee_addr", 8'ha5, ee_addr);
        chk("ee_small", 8'h25, ee_addr_s);
        // Mid-run reset returns counter, status and pointer to their reset values
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("pc", RESET_VECTOR, pc);
        chk("ee_addr", EE_PTR_RST, ee_addr);
        chk("status_q", STATUS_RST, status_q);
        // Bounded drain of outstanding notes
        for (int i = 0; i < 20 && q_i.size() + q_d.size() + q_s.size() > 0; i++) @(negedge clk);
        if (q_i.size() + q_d.size() + q_s.size() > 0) begin
            fails++;
        end
        close_out;
    end
endmodule : tb_mam_map

`default_nettype wire
